// ==== rtl/dac_output_sequencer.sv ====
// Two-channel DAC sequencer: APB registers, output FIFO, pacing and trigger.
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dac_output_sequencer #(
    parameter int DEPTH = 32768,
    parameter int DW = 12
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic arst_n,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins.
    input wire logic ext_dac_pacing_pin,
    input wire logic ext_trig_pin,
    // Converter side.
    output logic [DW-1:0] dac0_code,
    output logic [DW-1:0] dac1_code,
    output logic [2:0] dac0_range,
    output logic [2:0] dac1_range,
    output logic irq
);
    import dac_seq_pkg::*;
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] HALF = (AW+1)'(DEPTH / 2);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

    typedef struct packed {
        logic cont0;
        logic cont1;
        logic clk_ext;
        logic trig_ext;
        logic trig_fall;
        logic wave;
        logic [15:0] div;
        logic [2:0] rng0;
        logic [2:0] rng1;
        logic [DW-1:0] dac0;
        logic [DW-1:0] dac1;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] level;
        logic armed;
        logic running;
        logic [1:0] ist;
        logic [1:0] imask;
        logic [3:0] tb_cnt;
        logic [15:0] pcnt;
        logic pin_q;
        logic trig_q;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
    } state_type;

    state_type s;
    state_type next_s;
    logic [DW-1:0] mem [DEPTH];

    logic wr_acc;
    logic setup;
    logic dual;
    logic tb_tick;
    logic [15:0] eff_div;
    logic int_tick;
    logic ext_rise;
    logic pace;
    logic have;
    logic pop;
    logic push;
    logic stop;
    logic trig_ev;
    logic [AW-1:0] r1;
    logic [AW-1:0] r2;
    logic [DW-1:0] d0;
    logic [DW-1:0] d1;

    function automatic logic [AW-1:0] step(input logic [AW-1:0] x, input logic wv,
                                           input logic [AW-1:0] w);
        logic [AW-1:0] y;
        y = x + 1'b1;
        // A pattern replays from the start once the last loaded entry is used.
        if (wv && y == w) begin
            y = '0;
        end
        return y;
    endfunction

    assign wr_acc = psel & penable & s.pready & pwrite;
    assign setup = psel & ~penable;
    assign stop = wr_acc & (paddr == A_CMD) & pwdata[K_STOP];
    assign dual = s.cont0 & s.cont1;
    assign tb_tick = (s.tb_cnt == 4'(TB_DIV - 1));
    // The divisor is clamped so that software cannot exceed the rated update rate.
    assign eff_div = dual ? ((s.div < DIV_MIN_DUAL) ? DIV_MIN_DUAL : s.div)
                          : ((s.div < DIV_MIN_SINGLE) ? DIV_MIN_SINGLE : s.div);
    assign int_tick = tb_tick & (s.pcnt >= eff_div - 16'h0001);
    assign ext_rise = ext_dac_pacing_pin & ~s.pin_q;
    assign pace = s.running & (s.clk_ext ? ext_rise : int_tick);
    assign have = s.wave ? (s.level != '0) : (s.level >= (dual ? 2 : 1));
    assign pop = pace & have & ~stop;
    assign push = wr_acc & (paddr == A_FIFO) & (s.level < FULL);
    assign trig_ev = s.trig_ext ? (s.trig_fall ? (s.trig_q & ~ext_trig_pin)
                                               : (~s.trig_q & ext_trig_pin))
                                : (wr_acc & (paddr == A_CMD) & pwdata[K_SWTRIG]);
    assign r1 = step(s.rd, s.wave, s.wr);
    assign r2 = step(r1, s.wave, s.wr);
    assign d0 = mem[s.rd];
    assign d1 = mem[r1];

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[s.wr] <= pwdata[DW-1:0];
        end
    end

    always_comb begin
        logic [AW:0] lvl;
        logic [1:0] set;
        lvl = s.level;
        set = 2'b00;
        next_s = s;
        next_s.pin_q = ext_dac_pacing_pin;
        next_s.trig_q = ext_trig_pin;
        next_s.tb_cnt = tb_tick ? 4'h0 : s.tb_cnt + 4'h1;
        if (s.running && tb_tick) begin
            next_s.pcnt = int_tick ? 16'h0000 : s.pcnt + 16'h0001;
        end
        // APB answer: zero wait states, data captured in the setup cycle.
        next_s.pready = setup;
        next_s.pslverr = 1'b0;
        if (setup) begin
            next_s.prdata = 32'h0000_0000;
            case (paddr)
                A_CTRL: next_s.prdata = 32'({s.wave, s.trig_fall, s.trig_ext, s.clk_ext,
                                             s.cont1, s.cont0});
                A_CMD: next_s.prdata = 32'h0000_0000;
                A_DIV: next_s.prdata = 32'(s.div);
                A_RANGE: next_s.prdata = 32'({s.rng1, s.rng0});
                A_DATA0: next_s.prdata = 32'(s.dac0);
                A_DATA1: next_s.prdata = 32'(s.dac1);
                A_FIFO: next_s.prdata = 32'h0000_0000;
                A_STAT: next_s.prdata = 32'(s.level) | (32'({s.armed, s.running,
                                        s.level == '0, s.level == FULL}) << S_FLAGS);
                A_ISTAT: next_s.prdata = 32'(s.ist);
                A_IMASK: next_s.prdata = 32'(s.imask);
                default: next_s.pslverr = 1'b1;
            endcase
        end
        if (wr_acc) begin
            case (paddr)
                A_CTRL: begin
                    next_s.cont0 = pwdata[C_CONT0];
                    next_s.cont1 = pwdata[C_CONT1];
                    next_s.clk_ext = pwdata[C_CLK_EXT];
                    next_s.trig_ext = pwdata[C_TRIG_EXT];
                    next_s.trig_fall = pwdata[C_TRIG_FALL];
                    next_s.wave = pwdata[C_WAVE];
                end
                A_CMD: begin
                    if (pwdata[K_ARM] && (s.cont0 || s.cont1)) begin
                        next_s.armed = 1'b1;
                    end
                end
                A_DIV: next_s.div = pwdata[15:0];
                A_RANGE: begin
                    if (pwdata[2:0] <= RANGE_MAX) begin
                        next_s.rng0 = pwdata[2:0];
                    end
                    if (pwdata[R_CH1+2:R_CH1] <= RANGE_MAX) begin
                        next_s.rng1 = pwdata[R_CH1+2:R_CH1];
                    end
                end
                // A single value write bypasses pacing and trigger completely.
                A_DATA0: if (!s.cont0) next_s.dac0 = pwdata[DW-1:0];
                A_DATA1: if (!s.cont1) next_s.dac1 = pwdata[DW-1:0];
                A_IMASK: next_s.imask = pwdata[1:0];
                default: next_s.imask = s.imask;
            endcase
        end
        if (s.armed && trig_ev) begin
            next_s.armed = 1'b0;
            next_s.running = 1'b1;
            next_s.pcnt = 16'h0000;
        end
        if (push) begin
            next_s.wr = s.wr + 1'b1;
            lvl = lvl + 1'b1;
        end
        if (pop) begin
            if (dual) begin
                next_s.dac0 = d0;
                next_s.dac1 = d1;
                next_s.rd = r2;
            end else begin
                if (s.cont0) next_s.dac0 = d0;
                else next_s.dac1 = d0;
                next_s.rd = r1;
            end
            // A pattern stays loaded, so the level only drops in plain streaming.
            if (!s.wave) begin
                lvl = lvl - (dual ? (AW+1)'(2) : (AW+1)'(1));
            end
        end else if (pace) begin
            set[I_UNDER] = 1'b1;
        end
        if (s.level >= HALF && lvl < HALF && !s.wave) begin
            set[I_HALF] = 1'b1;
        end
        next_s.level = lvl;
        // Write one to clear; a new event in the same cycle survives.
        if (wr_acc && paddr == A_ISTAT) begin
            next_s.ist = s.ist & ~pwdata[1:0];
        end
        next_s.ist = next_s.ist | set;
        if (stop) begin
            next_s.wr = '0;
            next_s.rd = '0;
            next_s.level = '0;
            next_s.armed = 1'b0;
            next_s.running = 1'b0;
            next_s.pcnt = 16'h0000;
            next_s.ist[I_HALF] = 1'b0;
        end
        next_s.irq = |(next_s.ist & next_s.imask);
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
            s.div <= DIV_RST;
            s.rng0 <= RANGE_RST;
            s.rng1 <= RANGE_RST;
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign dac0_code = s.dac0;
    assign dac1_code = s.dac1;
    assign dac0_range = s.rng0;
    assign dac1_range = s.rng1;
    assign irq = s.irq;

    // Cycles since the previous pop, used only by the rate checks below.
    // A mode change while running is outside these checks; software stops first.
    logic [15:0] gap;
    logic gap_ok;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            gap <= 16'h0000;
            gap_ok <= 1'b0;
        end else begin
            gap <= pop ? 16'h0001 : ((gap == 16'hffff) ? gap : gap + 16'h0001);
            gap_ok <= stop ? 1'b0 : (pop ? 1'b1 : gap_ok);
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    a_single_write_now: assert property (wr_acc && paddr == A_DATA0 && !s.cont0
        |=> dac0_code == $past(pwdata[DW-1:0])) else $error("single write not applied");
    a_code_has_cause: assert property (!$stable(dac1_code)
        |-> $past(pop) || $past(wr_acc && paddr == A_DATA1)) else $error("code moved alone");
    a_single_rate: assert property (pop && !dual && !s.clk_ext && gap_ok
        |-> gap >= 16'(20)) else $error("single rate above limit");
    a_dual_rate: assert property (pop && dual && !s.clk_ext && gap_ok
        |-> gap >= 16'(40)) else $error("dual rate above limit");
    // A stop in the same cycle clears the half flag on purpose, so it is left out.
    a_half_request: assert property (s.level >= HALF && next_s.level < HALF && !s.wave
        && !stop |=> s.ist[I_HALF] && (irq || !s.imask[I_HALF]))
        else $error("half request lost");
    a_stop_flush: assert property (stop |=> s.level == '0 && !s.running
        && !s.ist[I_HALF] ##1 !pop) else $error("stop did not flush");
    a_empty_hold: assert property (pace && !have && !stop
        && !(wr_acc && (paddr == A_DATA0 || paddr == A_DATA1))
        |=> $stable(dac0_code) && $stable(dac1_code) && s.ist[I_UNDER])
        else $error("empty fifo not held");
    a_single_route: assert property (pop && !dual && s.cont1
        && !(wr_acc && paddr == A_DATA0)
        |=> dac1_code == $past(d0) && $stable(dac0_code)) else $error("single route wrong");
    a_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("ready not one pulse");
    a_dual_route: assert property (pop && dual |=> dac0_code == $past(d0)
        && dac1_code == $past(d1)) else $error("interleave wrong");
    a_wave_level: assert property (pop && s.wave && !push && !stop
        |=> s.level == $past(s.level)) else $error("pattern consumed");
    a_trig_start: assert property (s.armed && trig_ev && !stop
        |=> s.running && !s.armed) else $error("trigger missed");
endmodule
`default_nettype wire

// ==== rtl/dac_seq_pkg.sv ====
// Constants shared by the analog output sequencer.
// Behaviour
// - Two output channels, each holding its own 12-bit converter code.
// - Each channel keeps a range code: four internal ranges, external unipolar or bipolar.
// - Writing a channel data register in single value mode updates that code at once.
// - Single value writes ignore pacing and trigger settings; only range applies.
// - One continuous channel may be paced at up to 1 MS/s.
// - Two continuous channels are each limited to 500 kS/s; the divisor clamp enforces this and the 1 MS/s limit for internal pacing only.
// - Continuous mode per channel or both, with chosen pacing and trigger sources.
// - Continuous samples are buffered in a 32K-sample output FIFO filled by the host.
// - Samples leave the FIFO, one per running channel per pacing tick, only after the trigger.
// - Interrupt request when the FIFO level falls below half depth, 16K.
// - Refill and output go on until data runs out or software stops.
// - With both channels running, even samples go to channel 0, odd to 1.
// - Waveform mode replays the loaded pattern repeatedly without a break.
// - In waveform mode each running channel plays pattern samples at its pacing rate.
// - Internal pacing counts a 10 MHz time base; external pacing uses rising pin edges.
// - Trigger from software or an external input, rising or falling edge selectable.
package dac_seq_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned TB_HZ = 10_000_000;
    localparam int unsigned TB_DIV = CLK_HZ / TB_HZ;
    localparam int unsigned MAX_SINGLE_SPS = 1_000_000;
    localparam int unsigned MAX_DUAL_SPS = 500_000;
    localparam logic [15:0] DIV_MIN_SINGLE = 16'(TB_HZ / MAX_SINGLE_SPS);
    localparam logic [15:0] DIV_MIN_DUAL = 16'(TB_HZ / MAX_DUAL_SPS);
    localparam logic [15:0] DIV_RST = 16'h03e8;
    // Register byte offsets.
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_CMD = 8'h04;
    localparam logic [7:0] A_DIV = 8'h08;
    localparam logic [7:0] A_RANGE = 8'h0c;
    localparam logic [7:0] A_DATA0 = 8'h10;
    localparam logic [7:0] A_DATA1 = 8'h14;
    localparam logic [7:0] A_FIFO = 8'h18;
    localparam logic [7:0] A_STAT = 8'h1c;
    localparam logic [7:0] A_ISTAT = 8'h20;
    localparam logic [7:0] A_IMASK = 8'h24;
    // Control fields.
    localparam int C_CONT0 = 0;
    localparam int C_CONT1 = 1;
    localparam int C_CLK_EXT = 2;
    localparam int C_TRIG_EXT = 3;
    localparam int C_TRIG_FALL = 4;
    localparam int C_WAVE = 5;
    // Command fields.
    localparam int K_SWTRIG = 0;
    localparam int K_STOP = 1;
    localparam int K_ARM = 2;
    // Range field positions, the highest legal range code and the reset range code.
    localparam int R_CH1 = 3;
    localparam logic [2:0] RANGE_MAX = 3'h5;
    localparam logic [2:0] RANGE_RST = 3'h0;
    // Interrupt bits and the status flag position.
    localparam int I_HALF = 0;
    localparam int I_UNDER = 1;
    localparam int S_FLAGS = 16;
endpackage

// ==== verif/dac_host_model.sv ====
// Host model: APB master that loads samples and refills the FIFO when the bench calls it.
`timescale 1ns/1ps
`default_nettype none
module dac_host_model (
    // Clock.
    input wire logic ref_clk,
    // APB master side.
    output var logic psel,
    output var logic penable,
    output var logic pwrite,
    output var logic [7:0] paddr,
    output var logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    import dac_seq_pkg::*;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // The wait has no limit of its own; a silent slave runs into the bench timeout.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released data does not keep its last value.
        pwdata <= ~d;
    endtask
    // One block of samples counting up from base.
    task automatic refill(input int n, input logic [11:0] base);
        logic [31:0] r;
        logic e;
        for (int i = 0; i < n; i++) begin
            apb(1'b1, A_FIFO, {20'h0, base + 12'(i)}, r, e);
        end
    endtask
endmodule
`default_nettype wire

// ==== verif/dac_output_sequencer_tb_top.sv ====
// Testbench for the analog output sequencer.
`timescale 1ns/1ps
`default_nettype none
module dac_output_sequencer_tb_top;
    import dac_seq_pkg::*;
    // A shallow FIFO keeps the half-full scenario short.
    localparam int DP = 64;
    logic ref_clk, arst_n, psel, penable, pwrite, pready, pslverr, pace, trig, irq, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [11:0] c0, c1;
    logic [2:0] g0, g1;
    int failures = 0;
    int checks_done = 0;
    int cyc = 0;
    int k;
    dac_output_sequencer #(.DEPTH(DP), .DW(12)) dac_output_sequencer_inst (
        .ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_dac_pacing_pin(pace),
        .ext_trig_pin(trig), .dac0_code(c0), .dac1_code(c1), .dac0_range(g0),
        .dac1_range(g1), .irq(irq));
    dac_host_model host_model_inst (
        .ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Ends on the falling edge so that the committed write has landed.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host_model_inst.apb(1'b1, a, d, r, err);
        @(negedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        host_model_inst.apb(1'b0, a, 32'h0, r, err);
        chk(r, x);
    endtask
    task automatic lv(input int x);
        host_model_inst.apb(1'b0, A_STAT, 32'h0, r, err);
        chk(r & 32'h3ffff, {14'h0, x == 0, x == DP, 16'(x)});
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            pace <= 1'b1;
            repeat (2) @(posedge ref_clk);
            pace <= 1'b0;
            @(posedge ref_clk);
        end
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            give_verdict();
        end
    end
    initial begin
        arst_n = 1'b0;
        pace = 1'b0;
        trig = 1'b0;
        repeat (8) @(posedge ref_clk);
        arst_n <= 1'b1;
        rd(A_DIV, 32'h3e8);
        lv(0);
        chk({31'h0, irq}, 32'h0);
        rd(8'h3c, 32'h0);
        chk({31'h0, err}, 32'h1);
        wr(A_RANGE, 32'h2c);
        chk({26'h0, g1, g0}, 32'h2c);
        wr(A_RANGE, 32'h2e);
        chk({26'h0, g1, g0}, 32'h2c);
        wr(A_CTRL, 32'h0c);
        wr(A_DATA0, 32'habc);
        chk(32'(c0), 32'habc);
        wr(A_DATA1, 32'h123);
        chk(32'(c1), 32'h123);
        // Two channels from the internal pacer; the divisor is below the dual limit.
        wr(A_CTRL, 32'h0);
        for (k = 0; k < 4; k++) wr(A_FIFO, 32'h100 + k);
        wr(A_CTRL, 32'h3);
        wr(A_DIV, 32'ha);
        wr(A_IMASK, 32'h3);
        wr(A_CMD, 32'h4);
        repeat (60) @(posedge ref_clk);
        chk(32'(c0), 32'habc);
        wr(A_CMD, 32'h1);
        k = 0;
        while (c0 === 12'habc && k < 100) begin
            @(posedge ref_clk);
            k++;
        end
        chk(32'(k >= 38 && k <= 44), 32'h1);
        @(negedge ref_clk);
        chk(32'(c0), 32'h100);
        chk(32'(c1), 32'h101);
        repeat (42) @(negedge ref_clk);
        chk({c1, c0}, 32'h103102);
        repeat (42) @(negedge ref_clk);
        chk({c1, c0}, 32'h103102);
        chk({31'h0, irq}, 32'h1);
        wr(A_IMASK, 32'h0);
        rd(A_ISTAT, 32'h2);
        chk({31'h0, irq}, 32'h0);
        wr(A_IMASK, 32'h3);
        wr(A_CMD, 32'h2);
        lv(0);
        wr(A_ISTAT, 32'h2);
        rd(A_ISTAT, 32'h0);
        chk({31'h0, irq}, 32'h0);
        // One channel on the external pacing pin, external rising trigger.
        wr(A_CTRL, 32'h0d);
        host_model_inst.refill(DP, 12'h200);
        lv(DP);
        wr(A_CMD, 32'h4);
        tick(3);
        lv(DP);
        trig <= 1'b1;
        repeat (3) @(posedge ref_clk);
        tick(DP / 2);
        chk({31'h0, irq}, 32'h0);
        tick(1);
        rd(A_ISTAT, 32'h1);
        chk({31'h0, irq}, 32'h1);
        chk(32'(c0), 32'h200 + DP / 2);
        host_model_inst.refill(DP / 2, 12'h300);
        lv(DP - 1);
        wr(A_CMD, 32'h2);
        rd(A_ISTAT, 32'h0);
        lv(0);
        // Waveform replay on a falling external trigger.
        wr(A_CTRL, 32'h3d);
        for (k = 0; k < 3; k++) wr(A_FIFO, 32'h7a0 + k);
        wr(A_CMD, 32'h4);
        @(posedge ref_clk);
        trig <= 1'b0;
        repeat (3) @(posedge ref_clk);
        tick(4);
        chk(32'(c0), 32'h7a0);
        lv(3);
        tick(2);
        chk(32'(c0), 32'h7a2);
        // Channel 1 alone on the internal pacer; the divisor is below the single limit.
        wr(A_CMD, 32'h2);
        wr(A_CTRL, 32'h2);
        wr(A_DIV, 32'h1);
        wr(A_FIFO, 32'h5a1);
        wr(A_FIFO, 32'h5a2);
        wr(A_CMD, 32'h4);
        wr(A_CMD, 32'h1);
        k = 0;
        while (c1 !== 12'h5a1 && k < 100) begin
            @(posedge ref_clk);
            k++;
        end
        k = 0;
        while (c1 === 12'h5a1 && k < 100) begin
            @(posedge ref_clk);
            k++;
        end
        chk(32'(k >= 19 && k <= 21), 32'h1);
        chk({c1, c0}, 32'h5a27a2);
        give_verdict();
    end
endmodule
`default_nettype wire
